/* common/atc_pkg.sv */
// Constants for the ADC result handling block: ready flags, trigger selectors,
// digital comparators. Assumes a 16-bit register port and one 20 MHz clock.
package atc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 21;
  localparam int NUM_CMP  = 4;
  localparam int NUM_TRG  = 11;
  localparam int NUM_SRC  = 32;

  // ----------------------------------------------------------------
  // Register map (word addresses, own choice)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_READY_LO = 8'h00;
  localparam logic [7:0] ADDR_READY_HI = 8'h01;
  localparam logic [7:0] ADDR_TRG_BASE = 8'h10; // 0x10..0x1A, one per channel pair
  localparam logic [7:0] ADDR_CMP_BASE = 8'h20; // 8 words per comparator
  localparam logic [2:0] CMP_CON       = 3'h0;
  localparam logic [2:0] CMP_ENL       = 3'h1;
  localparam logic [2:0] CMP_ENH       = 3'h2;
  localparam logic [2:0] CMP_LO        = 3'h3;
  localparam logic [2:0] CMP_HI        = 3'h4;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int TRG_EVEN_LSB = 0;
  localparam int TRG_ODD_LSB  = 8;
  localparam int CON_CHNL_LSB = 8;
  localparam int CON_EN       = 7;
  localparam int CON_IE       = 6;
  localparam int CON_STAT     = 5;
  localparam int CON_BETWEEN_CRITERION     = 4;
  localparam int CON_AT_OR_ABOVE_HIGH_CRITERION     = 3;
  localparam int CON_BELOW_HIGH_CRITERION     = 2;
  localparam int CON_AT_OR_ABOVE_LOW_CRITERION     = 1;
  localparam int CON_BELOW_LOW_CRITERION     = 0;
  localparam logic [15:0] RESET_VAL = 16'h0000;

  // ----------------------------------------------------------------
  // Trigger selector codes
  // ----------------------------------------------------------------
  localparam logic [4:0] TRG_NONE    = 5'h00;
  localparam logic [4:0] TRG_SW      = 5'h01;
  localparam logic [4:0] TRG_SW_LVL  = 5'h02;
  localparam logic [4:0] TRG_PWM_FST = 5'h04;
  localparam logic [4:0] TRG_PWM_LST = 5'h0B;
  localparam logic [4:0] TRG_TMR_FST = 5'h0C;
  localparam logic [4:0] TRG_TMR_LST = 5'h10;
  localparam logic [4:0] TRG_LC3     = 5'h11;
  localparam logic [4:0] TRG_LC4     = 5'h12;
  localparam logic [4:0] TRG_TIRQ_FST= 5'h14;
  localparam logic [4:0] TRG_TIRQ_LST= 5'h18;
  localparam logic [4:0] TRG_LC1     = 5'h1C;
  localparam logic [4:0] TRG_LC2     = 5'h1D;
  localparam logic [4:0] TRG_PTG     = 5'h1E;
  localparam logic [4:0] TRG_EXT     = 5'h1F;

endpackage

/* design/atc_top.sv */
// ADC trigger selection, result ready flags and four digital comparators.
// Assumes the conversion core reports each result as a one-cycle strobe and
// that trigger sources are synchronous single-cycle pulses or levels.
`timescale 1ns/1ps
module atc_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Trigger sources
  input  wire logic        sw_common_trig,
  input  wire logic        sw_level_trig,
  input  wire logic [7:0]  pwm_trig,
  input  wire logic [4:0]  timer_trig,
  input  wire logic [4:0]  timer_irq,
  input  wire logic [3:0]  logic_cell_out,
  input  wire logic        peripheral_trigger_gen_out,
  input  wire logic        external_trigger_input,
  // Conversion core
  input  wire logic        result_valid,
  input  wire logic [4:0]  result_chan,
  input  wire logic [15:0] result_data,
  input  wire logic [20:0] result_consumed,
  output logic      [20:0] chan_convert_req,
  output logic      [20:0] chan_result_ready,
  output logic             common_adc_irq
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Maps a selector code onto the flat source vector; reserved codes are zero
  function automatic logic pick_src(input logic [4:0] code, input logic [atc_pkg::NUM_SRC-1:0] src);
    pick_src = src[code];
  endfunction

  function automatic logic is_write(input logic [7:0] a);
    is_write = reg_wr && (reg_addr == a);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [4:0]  trg_sel      [atc_pkg::NUM_CHAN];
  logic [4:0]  next_trg_sel [atc_pkg::NUM_CHAN];
  logic [20:0] next_ready;
  logic [20:0] next_convert;
  logic [15:0] cmp_con      [atc_pkg::NUM_CMP];
  logic [15:0] next_cmp_con [atc_pkg::NUM_CMP];
  logic [20:0] cmp_en       [atc_pkg::NUM_CMP];
  logic [20:0] next_cmp_en  [atc_pkg::NUM_CMP];
  logic [15:0] cmp_lo       [atc_pkg::NUM_CMP];
  logic [15:0] next_cmp_lo  [atc_pkg::NUM_CMP];
  logic [15:0] cmp_hi       [atc_pkg::NUM_CMP];
  logic [15:0] next_cmp_hi  [atc_pkg::NUM_CMP];
  logic [15:0] next_rdata;
  logic        next_irq;
  logic [atc_pkg::NUM_SRC-1:0] src_vec;

  // ----------------------------------------------------------------
  // Trigger source vector, indexed by selector code
  // ----------------------------------------------------------------
  always_comb begin
    src_vec                  = '0;
    src_vec[atc_pkg::TRG_SW]     = sw_common_trig;
    src_vec[atc_pkg::TRG_SW_LVL] = sw_level_trig;
    for (int i = 0; i < 8; i++) begin
      src_vec[int'(atc_pkg::TRG_PWM_FST) + i] = pwm_trig[i];
    end
    for (int i = 0; i < 5; i++) begin
      src_vec[int'(atc_pkg::TRG_TMR_FST) + i]  = timer_trig[i];
      src_vec[int'(atc_pkg::TRG_TIRQ_FST) + i] = timer_irq[i];
    end
    src_vec[atc_pkg::TRG_LC3] = logic_cell_out[2];
    src_vec[atc_pkg::TRG_LC4] = logic_cell_out[3];
    src_vec[atc_pkg::TRG_LC1] = logic_cell_out[0];
    src_vec[atc_pkg::TRG_LC2] = logic_cell_out[1];
    src_vec[atc_pkg::TRG_PTG] = peripheral_trigger_gen_out;
    src_vec[atc_pkg::TRG_EXT] = external_trigger_input;
  end

  // ----------------------------------------------------------------
  // Trigger selectors, ready flags and conversion requests
  // ----------------------------------------------------------------
  // Ready set wins over a same-cycle consume so a fresh result is never lost
  always_comb begin
    for (int c = 0; c < atc_pkg::NUM_CHAN; c++) begin
      next_trg_sel[c] = trg_sel[c];
      if (is_write(8'(atc_pkg::ADDR_TRG_BASE + 8'(c / 2)))) begin
        next_trg_sel[c] = (c % 2 == 0) ? reg_wdata[atc_pkg::TRG_EVEN_LSB +: 5]
                                        : reg_wdata[atc_pkg::TRG_ODD_LSB +: 5];
      end
      next_convert[c] = pick_src(trg_sel[c], src_vec);
      next_ready[c]   = (chan_result_ready[c] && !result_consumed[c])
                      || (result_valid && result_chan == 5'(c));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int c = 0; c < atc_pkg::NUM_CHAN; c++) trg_sel[c] <= 5'h00;
      chan_convert_req  <= '0;
      chan_result_ready <= '0;
    end else begin
      trg_sel           <= next_trg_sel;
      chan_convert_req  <= next_convert;
      chan_result_ready <= next_ready;
    end
  end

  // ----------------------------------------------------------------
  // Digital comparators
  // ----------------------------------------------------------------
  // Each comparator sees every new result once; the result is compared as
  // unsigned, since sign handling sits upstream in the conversion core.
  always_comb begin
    logic [7:0] base;
    logic       hit;
    logic       rd_con;
    base     = 8'h00;
    hit      = 1'b0;
    rd_con   = 1'b0;
    next_irq = 1'b0;
    for (int k = 0; k < atc_pkg::NUM_CMP; k++) begin
      base = 8'(atc_pkg::ADDR_CMP_BASE + 8'(k * 8));
      next_cmp_con[k] = cmp_con[k];
      next_cmp_en[k]  = cmp_en[k];
      next_cmp_lo[k]  = cmp_lo[k];
      next_cmp_hi[k]  = cmp_hi[k];
      rd_con = reg_rd && reg_addr == (base | 8'(atc_pkg::CMP_CON));
      if (is_write(base | 8'(atc_pkg::CMP_CON))) begin
        next_cmp_con[k][7:0] = {reg_wdata[7:6], cmp_con[k][atc_pkg::CON_STAT], reg_wdata[4:0]};
        if (!reg_wdata[atc_pkg::CON_EN]) next_cmp_con[k][atc_pkg::CON_STAT] = 1'b0;
      end
      if (is_write(base | 8'(atc_pkg::CMP_ENL))) next_cmp_en[k][15:0] = reg_wdata;
      if (is_write(base | 8'(atc_pkg::CMP_ENH))) next_cmp_en[k][20:16] = reg_wdata[4:0];
      if (is_write(base | 8'(atc_pkg::CMP_LO)))  next_cmp_lo[k] = reg_wdata;
      if (is_write(base | 8'(atc_pkg::CMP_HI)))  next_cmp_hi[k] = reg_wdata;
      // Reading the channel field clears status; an event in the same cycle wins
      if (rd_con) next_cmp_con[k][atc_pkg::CON_STAT] = 1'b0;
      hit = (cmp_con[k][atc_pkg::CON_BETWEEN_CRITERION] && result_data >= cmp_lo[k]
                                           && result_data <  cmp_hi[k])
         || (cmp_con[k][atc_pkg::CON_AT_OR_ABOVE_HIGH_CRITERION] && result_data >= cmp_hi[k])
         || (cmp_con[k][atc_pkg::CON_BELOW_HIGH_CRITERION] && result_data <  cmp_hi[k])
         || (cmp_con[k][atc_pkg::CON_AT_OR_ABOVE_LOW_CRITERION] && result_data >= cmp_lo[k])
         || (cmp_con[k][atc_pkg::CON_BELOW_LOW_CRITERION] && result_data <  cmp_lo[k]);
      if (result_valid && result_chan < 5'(atc_pkg::NUM_CHAN) && cmp_con[k][atc_pkg::CON_EN]
          && cmp_en[k][result_chan] && hit) begin
        next_cmp_con[k][atc_pkg::CON_STAT] = 1'b1;
        next_cmp_con[k][atc_pkg::CON_CHNL_LSB +: 5] = result_chan;
        if (cmp_con[k][atc_pkg::CON_IE]) next_irq = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int k = 0; k < atc_pkg::NUM_CMP; k++) begin
        cmp_con[k] <= atc_pkg::RESET_VAL;
        cmp_en[k]  <= '0;
        cmp_lo[k]  <= atc_pkg::RESET_VAL;
        cmp_hi[k]  <= atc_pkg::RESET_VAL;
      end
      common_adc_irq <= 1'b0;
    end else begin
      cmp_con        <= next_cmp_con;
      cmp_en         <= next_cmp_en;
      cmp_lo         <= next_cmp_lo;
      cmp_hi         <= next_cmp_hi;
      common_adc_irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  // Unmapped addresses and unimplemented bits read as zero
  always_comb begin
    int idx;
    int k;
    idx = 0;
    k = 0;
    next_rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == atc_pkg::ADDR_READY_LO) next_rdata = chan_result_ready[15:0];
      if (reg_addr == atc_pkg::ADDR_READY_HI) next_rdata = {11'h000, chan_result_ready[20:16]};
      if (reg_addr >= atc_pkg::ADDR_TRG_BASE && reg_addr < atc_pkg::ADDR_TRG_BASE + 8'(atc_pkg::NUM_TRG)) begin
        idx = 2 * int'(reg_addr - atc_pkg::ADDR_TRG_BASE);
        next_rdata[4:0] = trg_sel[idx];
        if (idx + 1 < atc_pkg::NUM_CHAN) next_rdata[12:8] = trg_sel[idx + 1];
      end
      if (reg_addr >= atc_pkg::ADDR_CMP_BASE && reg_addr < atc_pkg::ADDR_CMP_BASE + 8'h20) begin
        k = int'(reg_addr[4:3]);
        unique case (reg_addr[2:0])
          atc_pkg::CMP_CON: next_rdata = {3'h0, cmp_con[k][12:0]};
          atc_pkg::CMP_ENL: next_rdata = cmp_en[k][15:0];
          atc_pkg::CMP_ENH: next_rdata = {11'h000, cmp_en[k][20:16]};
          atc_pkg::CMP_LO:  next_rdata = cmp_lo[k];
          atc_pkg::CMP_HI:  next_rdata = cmp_hi[k];
          default:          next_rdata = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

/* bench/atc_top_sva.sv */
// Checker for atc_top: read data shape, ready flags and comparator interrupt.
// Bound to every atc_top instance and sees its ports only.
`timescale 1ns/1ps
module atc_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        result_valid,
  input wire logic [4:0]  result_chan,
  input wire logic [20:0] result_consumed,
  input wire logic [20:0] chan_result_ready,
  input wire logic        common_adc_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A result strobe for one of the 21 real channels
  sequence s_result;
    result_valid && result_chan < 5'h15;
  endsequence
  // Read of a trigger pair: spare bits 7:5 and 15:13 stay zero whatever was written
  a_trg_resv_zero: assert property ($past(reg_rd) && $past(reg_addr[7:4]) == 4'h1 |->
    (reg_rdata & 16'hE0E0) == 16'h0000) else $error("trigger register spare bits set");
  a_ready_hi_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h01 |->
    reg_rdata[15:5] == 11'h000) else $error("ready high spare bits set");
  a_enh_spare_zero: assert property ($past(reg_rd) && $past(reg_addr[7:5]) == 3'h1 &&
    $past(reg_addr[2:0]) == 3'h2 |-> reg_rdata[15:5] == 11'h000) else $error("enable high spare bits set");
  a_chnl_code_legal: assert property ($past(reg_rd) && $past(reg_addr[7:5]) == 3'h1 &&
    $past(reg_addr[2:0]) == 3'h0 |-> reg_rdata[15:13] == 3'h0 && reg_rdata[12:8] < 5'h15)
    else $error("channel field out of range");
  a_ready_sets: assert property (s_result |=> chan_result_ready[$past(result_chan)])
    else $error("ready flag not set after result");
  a_ready_cause: assert property (|(chan_result_ready & ~$past(chan_result_ready)) |->
    $past(result_valid)) else $error("ready flag rose without result");
  a_ready_consumed: assert property (|result_consumed && !result_valid |=>
    (chan_result_ready & $past(result_consumed)) == 21'h000000) else $error("ready flag kept after consume");
  // The common interrupt only follows a result one cycle earlier
  a_irq_cause: assert property (common_adc_irq |-> $past(result_valid))
    else $error("interrupt without result");
endmodule
bind atc_top atc_chk i_chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .result_valid(result_valid), .result_chan(result_chan),
  .result_consumed(result_consumed), .chan_result_ready(chan_result_ready), .common_adc_irq(common_adc_irq));

/* bench/atc_core_model.sv */
// Conversion core and trigger source model facing atc_top.
// Bench calls its tasks; all outputs change right after a rising edge.
`timescale 1ns/1ps
module atc_core_model (
  input  wire logic        clk_sys,
  output logic      [25:0] src,
  output logic             result_valid,
  output logic      [4:0]  result_chan,
  output logic      [15:0] result_data,
  output logic      [20:0] result_consumed
);
  // Quiet start; data lines idle on a non-zero pattern
  initial begin
    src = 26'h0000000;
    result_valid = 1'b0;
    result_chan = 5'h1F;
    result_data = 16'hA5A5;
    result_consumed = 21'h000000;
  end
  // One cycle of a source pattern
  task automatic fire(input logic [25:0] s);
    @(posedge clk_sys);
    src <= s;
    @(posedge clk_sys);
    src <= 26'h0000000;
  endtask
  // One result strobe; stale data inverted so nothing lives on it
  task automatic convert(input logic [4:0] ch, input logic [15:0] d);
    @(posedge clk_sys);
    result_valid <= 1'b1;
    result_chan <= ch;
    result_data <= d;
    @(posedge clk_sys);
    result_valid <= 1'b0;
    result_chan <= ~ch;
    result_data <= ~d;
  endtask
  // Buffer read of one channel
  task automatic consume(input logic [4:0] ch);
    @(posedge clk_sys);
    result_consumed <= 21'h000001 << ch;
    @(posedge clk_sys);
    result_consumed <= 21'h000000;
  endtask
endmodule

/* bench/atc_top_tb_top.sv */
// Top testbench for atc_top: register tasks, trigger table, comparator table.
// Assumes the core model in atc_core_model and the bound checker.
`timescale 1ns/1ps
module atc_top_tb_top;
  localparam logic [15:0] VALS [4] = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200};
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [25:0] src;
  logic        result_valid;
  logic [4:0]  result_chan;
  logic [15:0] result_data;
  logic [20:0] result_consumed;
  logic [20:0] chan_convert_req;
  logic [20:0] chan_result_ready;
  logic        common_adc_irq;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // 50 ns clock
  always #25 clk_sys = ~clk_sys;
  atc_core_model i_core (.clk_sys(clk_sys), .src(src), .result_valid(result_valid), .result_chan(result_chan),
    .result_data(result_data), .result_consumed(result_consumed));
  atc_top i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sw_common_trig(src[0]), .sw_level_trig(src[1]),
    .pwm_trig(src[9:2]), .timer_trig(src[14:10]), .timer_irq(src[19:15]), .logic_cell_out(src[23:20]),
    .peripheral_trigger_gen_out(src[24]), .external_trigger_input(src[25]), .result_valid(result_valid),
    .result_chan(result_chan), .result_data(result_data), .result_consumed(result_consumed),
    .chan_convert_req(chan_convert_req), .chan_result_ready(chan_result_ready), .common_adc_irq(common_adc_irq));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // Source bit that a selector code picks, or -1 for none
  function automatic int src_of(input int c);
    if (c == 1 || c == 2) return c - 1;
    if (c >= 4 && c <= 16) return c - 2;
    if (c == 17 || c == 18) return c + 5;
    if (c >= 20 && c <= 24) return c - 5;
    if (c == 28 || c == 29) return c - 8;
    if (c >= 30) return c - 6;
    return -1;
  endfunction
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end
  // Main sequence
  initial begin
    int s;
    int ch;
    logic [7:0] a;
    logic [15:0] d;
    logic [15:0] q;
    logic e;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h00, q); chk("ready_lo", q, 16'h0000);
    rd(8'h20, q); chk("con_reset", q, 16'h0000);
    wr(8'h11, 16'hFFFF);
    rd(8'h11, q); chk("trg_pair", q, 16'h1F1F);
    // Channels 2 and 3 back to no trigger, else they answer the sweep below
    wr(8'h11, 16'h0000);
    for (int c = 0; c < 32; c++) begin
      wr(8'h10, {3'h0, c[4:0], 3'h0, c[4:0]});
      s = src_of(c);
      i_core.fire(s < 0 ? 26'h3FFFFFF : 26'h0000001 << s);
      #1 chk("req_hit", chan_convert_req[15:0], s < 0 ? 16'h0000 : 16'h0003);
      if (s >= 0) begin
        i_core.fire(~(26'h0000001 << s));
        #1 chk("req_miss", chan_convert_req[15:0], 16'h0000);
      end
    end
    // Last pair register holds channel 20 only; its upper half has no channel
    wr(8'h1A, 16'hFF01);
    rd(8'h1A, q); chk("trg_last", q, 16'h0001);
    i_core.fire(26'h0000001);
    #1 chk("req_ch20", {11'h000, chan_convert_req[20:16]}, 16'h0010);
    for (int k = 0; k < 4; k++) begin
      a = 8'(8'h20 + 8 * k);
      wr(a + 8'h01, 16'hFFFF);
      wr(a + 8'h02, 16'h001F);
      wr(a + 8'h03, 16'h0100);
      wr(a + 8'h04, 16'h0200);
    end
    for (int b = 0; b < 5; b++) begin
      for (int v = 0; v < 4; v++) begin
        a = 8'(8'h20 + 8 * (b % 4));
        ch = 4 * b + v;
        d = VALS[v];
        e = (b == 4) ? (d >= 16'h0100 && d < 16'h0200) : (b == 3) ? d >= 16'h0200 :
            (b == 2) ? d < 16'h0200 : (b == 1) ? d >= 16'h0100 : d < 16'h0100;
        wr(a, 16'h00C0 | (16'h0001 << b));
        i_core.convert(5'(ch), d);
        #1 chk("irq", 16'(common_adc_irq), 16'(e));
        chk("ready_set", 16'(chan_result_ready[ch]), 16'h0001);
        rd(a, q);
        if (e) chk("con_event", q, {3'h0, 5'(ch), 8'hE0 | 8'(1 << b)});
        else chk("con_quiet", {8'h00, q[7:0]}, 16'h00C0 | (16'h0001 << b));
        rd(a, q); chk("stat_clr", {8'h00, q[7:0]}, 16'h00C0 | (16'h0001 << b));
        i_core.consume(5'(ch));
        #1 chk("ready_clr", 16'(chan_result_ready[ch]), 16'h0000);
        wr(a, 16'h0000);
      end
    end
    wr(8'h22, 16'hFFE0);
    rd(8'h22, q); chk("enh", q, 16'h0000);
    wr(8'h20, 16'h00C2);
    i_core.convert(5'h14, 16'h0300);
    #1 chk("irq_off_chan", 16'(common_adc_irq), 16'h0000);
    rd(8'h20, q); chk("no_stat", {8'h00, q[7:0]}, 16'h00C2);
    rd(8'h01, q); chk("ready_hi", q, 16'h0010);
    wr(8'h22, 16'h001F);
    // Interrupt off, so this event only sets the status left for the disable
    wr(8'h20, 16'h0082);
    i_core.convert(5'h14, 16'h0300);
    #1 chk("irq_masked", 16'(common_adc_irq), 16'h0000);
    wr(8'h20, 16'h0002);
    rd(8'h20, q); chk("off_clears", {8'h00, q[7:0]}, 16'h0002);
    report_and_stop;
  end
endmodule
